//--- rtl/dsp_defines.vh
`ifndef DSP_DEFINES_VH
`define DSP_DEFINES_VH

// clock and timing
`define DSP_CLK_MHZ 125
`define DSP_FSW_LO_KHZ 500
`define DSP_FSW_HI_KHZ 1000
`define DSP_PERIOD_LO ((`DSP_CLK_MHZ * 1000) / `DSP_FSW_LO_KHZ)
`define DSP_PERIOD_HI ((`DSP_CLK_MHZ * 1000) / `DSP_FSW_HI_KHZ)
`define DSP_DEAD_NS 20
`define DSP_DEAD_CYC ((`DSP_DEAD_NS * `DSP_CLK_MHZ + 999) / 1000)

// overcurrent period counting
`define DSP_OCP_FAULT_PERIODS 16
`define DSP_OCP_CLEAN_PERIODS 3

// gate-drive setpoint codes
`define DSP_SETPT_12V 2'b00
`define DSP_SETPT_15V 2'b01
`define DSP_SETPT_10V 2'b10
`define DSP_SETPT_7V 2'b11

// gate-drive voltage, volts
`define DSP_DRV_7V 5'h07
`define DSP_DRV_10V 5'h0a
`define DSP_DRV_12V 5'h0c
`define DSP_DRV_15V 5'h0f

// buck target, units of 100 mV
`define DSP_BUCK_6V5 7'h41
`define DSP_BUCK_7V0 7'h46
`define DSP_BUCK_8V0 7'h50

// fault status bit positions
`define DSP_ST_LS_UVLO 0
`define DSP_ST_HS_UVLO 1
`define DSP_ST_BUCK_OVLO 2
`define DSP_ST_BUCK_OCP 3
`define DSP_ST_EXT_WARN 4
`define DSP_ST_WIDTH 8
`define DSP_ST_RESET 8'h00

`endif

//--- rtl/dsp_uvlo.v
`include "dsp_defines.vh"

module dsp_uvlo (
    input wire clk,
    input wire rst,
    input wire rail_above_rise,
    input wire rail_below_fall,
    output reg lockout_reg,
    output reg fault_reg
);

reg released_reg;

// lockout with hysteresis; a fault is only a drop after first release,
// so the start-up ramp itself never reports one
always @(posedge clk) begin
    if (rst) begin
        lockout_reg <= 1'b1;
        released_reg <= 1'b0;
        fault_reg <= 1'b0;
    end else begin
        if (rail_below_fall) begin
            lockout_reg <= 1'b1;
            if (released_reg)
                fault_reg <= 1'b1;
        end else if (rail_above_rise) begin
            lockout_reg <= 1'b0;
            released_reg <= 1'b1;
            fault_reg <= 1'b0;
        end
    end
end

endmodule

//--- rtl/dsp_ocp_count.v
`include "dsp_defines.vh"

module dsp_ocp_count (
    input wire clk,
    input wire rst,
    input wire period_end,
    input wire oc_seen,
    output reg fault_reg,
    output reg [4:0] count_reg
);

reg [1:0] clean_reg;

localparam [31:0] FAULT_FULL = `DSP_OCP_FAULT_PERIODS;
localparam [31:0] PRE_FAULT_FULL = `DSP_OCP_FAULT_PERIODS - 1;
localparam [31:0] CLEAN_LAST_FULL = `DSP_OCP_CLEAN_PERIODS - 1;
localparam [4:0] FAULT_CNT = FAULT_FULL[4:0];
localparam [4:0] PRE_FAULT_CNT = PRE_FAULT_FULL[4:0];
localparam [1:0] CLEAN_LAST = CLEAN_LAST_FULL[1:0];

always @(posedge clk) begin
    if (rst) begin
        count_reg <= 5'h00;
        clean_reg <= 2'h0;
        fault_reg <= 1'b0;
    end else if (period_end) begin
        if (oc_seen) begin
            clean_reg <= 2'h0;
            if (count_reg != FAULT_CNT)
                count_reg <= count_reg + 5'h01;
            if (count_reg == PRE_FAULT_CNT)
                fault_reg <= 1'b1;
        end else if (clean_reg == CLEAN_LAST) begin
            clean_reg <= 2'h0;
            count_reg <= 5'h00;
            fault_reg <= 1'b0;
        end else begin
            clean_reg <= clean_reg + 2'h1;
        end
    end
end

endmodule

//--- rtl/dsp_protect.v
// Operation
// - pwm to gate outputs blocked while low-side rail locked out
// - low-side rail falling below threshold after release registers a fault
// - low-side rail fault pulls fault_out_n low
// - high-side rail lockout blocks pwm; drop below falling threshold is fault
// - high-side rail fault pulls fault_out_n low
// - driver off and gate voltage rising turns on strong pull-down
// - buck control runs regardless of gate driver faults
// - buck switching frequency chosen by buck_switch_freq_sel
// - setpoint b11 gives 7 V / 6.5 V, b10 gives 10 V / 7 V
// - setpoint b00 gives 12 V, b01 gives 15 V, both 8 V buck
// - buck overvoltage turns off both buck switches
// - peak current ends high-side pulse until next period
// - low-side switch follows truncated pulse only after dead time
// - 16 peak-current periods with no run of three clean periods between them raise buck overcurrent fault
// - after that fault the buck keeps running in current limit
// - three clean periods in a row clear the period counter and the overcurrent fault
// - buck overcurrent fault sets buck_overcurrent_flag in status
`include "dsp_defines.vh"

module dsp_protect (
    input wire clk,
    input wire rst,
    input wire chip_enable,
    input wire driver_enable_pin,
    input wire [5:0] pwm_in,
    input wire [5:0] gate_voltage_high,
    input wire ls_rail_above_rise,
    input wire ls_rail_below_fall,
    input wire hs_rail_above_rise,
    input wire hs_rail_below_fall,
    input wire [1:0] gate_drive_setpoint,
    input wire buck_switch_freq_sel,
    input wire [7:0] buck_on_cycles,
    input wire buck_output_overvoltage,
    input wire buck_peak_current,
    input wire ext_warning,
    input wire status_clear,
    output reg [5:0] gate_out,
    output reg [5:0] strong_pulldown,
    output reg buck_hs_on,
    output reg buck_ls_on,
    output reg [6:0] buck_target,
    output reg [4:0] gate_drive_voltage,
    output reg buck_ocp_fault,
    output reg [7:0] fault_status_reg,
    output reg fault_out_n
);

localparam ST_OFF = 3'd0;
localparam ST_DT_HS = 3'd1;
localparam ST_HS = 3'd2;
localparam ST_DT_LS = 3'd3;
localparam ST_LS = 3'd4;

// timing constants are cut down to counter width on purpose
localparam [31:0] DEAD_FULL = `DSP_DEAD_CYC;
localparam [31:0] LAST_LO_FULL = `DSP_PERIOD_LO - 1;
localparam [31:0] LAST_HI_FULL = `DSP_PERIOD_HI - 1;
localparam [7:0] DEAD_CYC = DEAD_FULL[7:0];
localparam [7:0] LAST_LO = LAST_LO_FULL[7:0];
localparam [7:0] LAST_HI = LAST_HI_FULL[7:0];

// last count of the switching period for the selected frequency
function [7:0] period_last;
    input sel;
    begin
        if (sel)
            period_last = LAST_HI;
        else
            period_last = LAST_LO;
    end
endfunction

function [6:0] buck_target_of;
    input [1:0] code;
    begin
        case (code)
            `DSP_SETPT_7V: buck_target_of = `DSP_BUCK_6V5;
            `DSP_SETPT_10V: buck_target_of = `DSP_BUCK_7V0;
            `DSP_SETPT_12V: buck_target_of = `DSP_BUCK_8V0;
            `DSP_SETPT_15V: buck_target_of = `DSP_BUCK_8V0;
            default: buck_target_of = `DSP_BUCK_8V0;
        endcase
    end
endfunction

function [4:0] drive_volt_of;
    input [1:0] code;
    begin
        case (code)
            `DSP_SETPT_7V: drive_volt_of = `DSP_DRV_7V;
            `DSP_SETPT_10V: drive_volt_of = `DSP_DRV_10V;
            `DSP_SETPT_12V: drive_volt_of = `DSP_DRV_12V;
            `DSP_SETPT_15V: drive_volt_of = `DSP_DRV_15V;
            default: drive_volt_of = `DSP_DRV_12V;
        endcase
    end
endfunction

wire ls_lockout;
wire ls_fault;
wire hs_lockout;
wire hs_fault;
wire ocp_fault;
wire [4:0] ocp_count;

dsp_uvlo u_ls_uvlo (
    .clk(clk),
    .rst(rst),
    .rail_above_rise(ls_rail_above_rise),
    .rail_below_fall(ls_rail_below_fall),
    .lockout_reg(ls_lockout),
    .fault_reg(ls_fault)
);

dsp_uvlo u_hs_uvlo (
    .clk(clk),
    .rst(rst),
    .rail_above_rise(hs_rail_above_rise),
    .rail_below_fall(hs_rail_below_fall),
    .lockout_reg(hs_lockout),
    .fault_reg(hs_fault)
);

// ---------------- gate driver side ----------------

wire driver_on;
wire pwm_allowed;

assign driver_on = driver_enable_pin & chip_enable;
// a lockout on either rail masks all six gates, not only its own side
assign pwm_allowed = driver_on & ~ls_lockout & ~hs_lockout;

// one cycle of latency from pwm_in to gate_out
always @(posedge clk) begin
    if (rst) begin
        gate_out <= 6'h00;
    end else begin
        gate_out <= pwm_in & {6{pwm_allowed}};
    end
end

always @(posedge clk) begin
    if (rst) begin
        strong_pulldown <= 6'h00;
    end else begin
        // the weak pull-down is passive; only the strong one is switched
        strong_pulldown <= gate_voltage_high & {6{~driver_on}};
    end
end

// ---------------- buck converter side ----------------
// nothing on the buck side looks at the gate driver faults, so the supply for the
// controller survives a charge pump collapse

reg [7:0] period_cnt_reg;
reg [7:0] period_cnt_next;
reg [7:0] phase_cnt_reg;
reg [7:0] phase_cnt_next;
reg [2:0] state_reg;
reg [2:0] state_next;
reg oc_seen_reg;
reg oc_seen_next;
wire period_end;
wire [7:0] last_cnt;

assign last_cnt = period_last(buck_switch_freq_sel);
// a frequency change mid-period just shortens or stretches that period
assign period_end = (period_cnt_reg >= last_cnt);

always @* begin
    period_cnt_next = period_cnt_reg + 8'h01;
    if (period_end)
        period_cnt_next = 8'h00;
end

// overvoltage is applied last so it beats every other transition
always @* begin
    state_next = state_reg;
    phase_cnt_next = phase_cnt_reg + 8'h01;
    oc_seen_next = oc_seen_reg;
    if (period_end)
        oc_seen_next = 1'b0;
    case (state_reg)
        ST_OFF: begin
            phase_cnt_next = 8'h00;
            if (period_end && !buck_output_overvoltage) begin
                state_next = ST_DT_HS;
            end
        end
        ST_DT_HS: begin
            if (phase_cnt_reg >= DEAD_CYC - 8'h01) begin
                state_next = ST_HS;
                phase_cnt_next = 8'h00;
            end
        end
        ST_HS: begin
            if (buck_peak_current) begin
                // truncation holds until the next period start
                state_next = ST_DT_LS;
                phase_cnt_next = 8'h00;
                oc_seen_next = 1'b1;
            // an on-time longer than the period is cut at the period end
            end else if (phase_cnt_reg >= buck_on_cycles - 8'h01 ||
                         period_end) begin
                state_next = ST_DT_LS;
                phase_cnt_next = 8'h00;
            end
        end
        ST_DT_LS: begin
            if (phase_cnt_reg >= DEAD_CYC - 8'h01) begin
                state_next = ST_LS;
                phase_cnt_next = 8'h00;
            end
        end
        ST_LS: begin
            if (period_end) begin
                state_next = ST_DT_HS;
                phase_cnt_next = 8'h00;
            end
        end
        default: begin
            state_next = ST_OFF;
            phase_cnt_next = 8'h00;
        end
    endcase
    if (buck_output_overvoltage) begin
        state_next = ST_OFF;
        phase_cnt_next = 8'h00;
    end
end

// the period counter keeps running through overvoltage, so a restart
// always lines up with a period start
always @(posedge clk) begin
    if (rst) begin
        period_cnt_reg <= 8'h00;
    end else begin
        period_cnt_reg <= period_cnt_next;
    end
end

always @(posedge clk) begin
    if (rst) begin
        phase_cnt_reg <= 8'h00;
        state_reg <= ST_OFF;
        oc_seen_reg <= 1'b0;
    end else begin
        phase_cnt_reg <= phase_cnt_next;
        state_reg <= state_next;
        oc_seen_reg <= oc_seen_next;
    end
end

// switch commands come from the next state, so they move with the state
always @(posedge clk) begin
    if (rst) begin
        buck_hs_on <= 1'b0;
        buck_ls_on <= 1'b0;
    end else begin
        // the overcurrent fault does not stop switching
        buck_hs_on <= (state_next == ST_HS);
        buck_ls_on <= (state_next == ST_LS);
    end
end

// peak current seen on the closing cycle of a period still counts
wire oc_this_period;
assign oc_this_period = oc_seen_reg |
    (buck_peak_current && state_reg == ST_HS);

// the counter only moves at period ends, so one period counts once
dsp_ocp_count u_ocp_count (
    .clk(clk),
    .rst(rst),
    .period_end(period_end),
    .oc_seen(oc_this_period),
    .fault_reg(ocp_fault),
    .count_reg(ocp_count)
);

// setpoint decode feeds the buck reference and the pump target
// registered so a setpoint change cannot glitch the reference
always @(posedge clk) begin
    if (rst) begin
        buck_target <= `DSP_BUCK_8V0;
    end else begin
        buck_target <= buck_target_of(gate_drive_setpoint);
    end
end

always @(posedge clk) begin
    if (rst) begin
        gate_drive_voltage <= `DSP_DRV_12V;
    end else begin
        gate_drive_voltage <= drive_volt_of(gate_drive_setpoint);
    end
end

// ---------------- fault reporting ----------------

wire [7:0] fault_events;
wire any_active;

// one event per status bit; the upper bits read zero
assign fault_events[`DSP_ST_LS_UVLO] = ls_fault;
assign fault_events[`DSP_ST_HS_UVLO] = hs_fault;
assign fault_events[`DSP_ST_BUCK_OVLO] = buck_output_overvoltage;
assign fault_events[`DSP_ST_BUCK_OCP] = ocp_fault;
assign fault_events[`DSP_ST_EXT_WARN] = ext_warning;
assign fault_events[7:5] = 3'h0;

assign any_active = ls_fault | hs_fault | ocp_fault |
    buck_output_overvoltage | ext_warning;

always @(posedge clk) begin
    if (rst) begin
        fault_status_reg <= `DSP_ST_RESET;
    end else begin
        // a new event in the clearing cycle survives the clear
        if (status_clear)
            fault_status_reg <= fault_events;
        else
            fault_status_reg <= fault_status_reg | fault_events;
    end
end

// the pin is a level: it releases as soon as every source has dropped
always @(posedge clk) begin
    if (rst) begin
        buck_ocp_fault <= 1'b0;
        fault_out_n <= 1'b1;
    end else begin
        buck_ocp_fault <= ocp_fault;
        fault_out_n <= ~any_active;
    end
end

endmodule

//--- tb/dsp_protect_assertions.sv
module dsp_chk (
    input logic clk,
    input logic rst,
    input logic chip_enable,
    input logic driver_enable_pin,
    input logic [5:0] gate_voltage_high,
    input logic [1:0] gate_drive_setpoint,
    input logic buck_output_overvoltage,
    input logic buck_peak_current,
    input logic ext_warning,
    input logic status_clear,
    input logic [5:0] strong_pulldown,
    input logic buck_hs_on,
    input logic buck_ls_on,
    input logic [6:0] buck_target,
    input logic [4:0] gate_drive_voltage,
    input logic buck_ocp_fault,
    input logic [7:0] fault_status_reg,
    input logic fault_out_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    wire [1:0] sp = gate_drive_setpoint;
    wire [11:0] exp_pair = sp[1] ?
        (sp[0] ? {7'h41, 5'h07} : {7'h46, 5'h0a}) :
        (sp[0] ? {7'h50, 5'h0f} : {7'h50, 5'h0c});
    sequence sp_hi_held;
        sp[1] ##1 $stable(sp);
    endsequence
    sequence sp_lo_held;
        !sp[1] ##1 $stable(sp);
    endsequence
    chk_pulldown_on: assert property (
        gate_voltage_high != 6'h00 && !(driver_enable_pin && chip_enable)
        |=> strong_pulldown == $past(gate_voltage_high))
        else $error("pull-down does not follow gate sense");
    chk_target_hi: assert property (
        sp_hi_held |-> {buck_target, gate_drive_voltage} == exp_pair)
        else $error("low drive setpoint mapping off");
    chk_target_lo: assert property (
        sp_lo_held |-> {buck_target, gate_drive_voltage} == exp_pair)
        else $error("high drive setpoint mapping off");
    chk_ovlo_stop: assert property (
        buck_output_overvoltage |=> !buck_hs_on && !buck_ls_on)
        else $error("buck switch on during overvoltage");
    chk_peak_cut: assert property (
        buck_hs_on && buck_peak_current |-> ##[1:2] !buck_hs_on [*3])
        else $error("high-side pulse not cut by peak current");
    chk_dead_time: assert property (
        $fell(buck_hs_on) |-> !buck_ls_on [*2])
        else $error("low-side on without dead time");
    chk_ocp_pin: assert property (
        $rose(buck_ocp_fault) |-> !fault_out_n && fault_status_reg[3])
        else $error("overcurrent fault not reported");
    chk_flag_sticky: assert property (
        fault_status_reg[3] && !status_clear |=> fault_status_reg[3])
        else $error("overcurrent flag lost without clear");
    chk_warn_pin: assert property (
        ext_warning |=> !fault_out_n && fault_status_reg[4])
        else $error("warning does not pull fault pin");
endmodule

//--- tb/dsp_mcu.sv
module dsp_mcu (
    input logic clk,
    input logic rst,
    input logic want_en,
    input logic want_freq,
    input logic clr_req,
    input logic slow,
    input logic [1:0] want_setpt,
    output logic driver_enable_pin,
    output logic buck_switch_freq_sel,
    output logic status_clear,
    output logic [1:0] gate_drive_setpoint
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] wait_cnt = 3'h0;
    initial begin
        driver_enable_pin = 1'b0;
        buck_switch_freq_sel = 1'b0;
        status_clear = 1'b0;
        gate_drive_setpoint = 2'h0;
    end
    always @(negedge clk) begin
        driver_enable_pin <= want_en;
        gate_drive_setpoint <= want_setpt;
        // frequency only loaded under reset, as a fuse load would be
        if (rst)
            buck_switch_freq_sel <= want_freq;
        status_clear <= wait_cnt == 3'h1;
        if (clr_req)
            wait_cnt <= slow ? 3'h5 : 3'h1;
        else if (wait_cnt != 3'h0)
            wait_cnt <= wait_cnt - 3'h1;
    end
endmodule

//--- tb/tb_dsp_protect.sv
module tb_dsp_protect;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, chip_enable = 1, want_en = 0, want_freq = 0;
    logic clr_req = 0, slow = 0, ocp_on = 0, ext_warning = 0;
    logic buck_output_overvoltage = 0, buck_peak_current = 0;
    logic [1:0] above = 0, below = 0, want_setpt = 0;
    logic [5:0] pwm_in = 0, gate_voltage_high = 0;
    logic [7:0] buck_on_cycles = 8'h20, lfsr = 8'h15, r;
    logic [19:0] exp_q[$];
    logic [6:0] tgt[4] = '{7'h50, 7'h50, 7'h46, 7'h41};
    logic [4:0] drv[4] = '{5'h0c, 5'h0f, 5'h0a, 5'h07};
    wire driver_enable_pin, buck_switch_freq_sel, status_clear;
    wire buck_hs_on, buck_ls_on, buck_ocp_fault, fault_out_n;
    wire [1:0] gate_drive_setpoint;
    wire [5:0] gate_out, strong_pulldown;
    wire [6:0] buck_target;
    wire [4:0] gate_drive_voltage;
    wire [7:0] fault_status_reg;
    int error_cnt = 0, total_checks = 0, cyc = 0, rises = 0;
    int i, n, base = 0, per = 0, last_rise = 0;
    event look;
    dsp_protect i_dsp_protect (
        .clk, .rst, .chip_enable, .driver_enable_pin, .pwm_in,
        .gate_voltage_high, .ls_rail_above_rise(above[0]),
        .ls_rail_below_fall(below[0]), .hs_rail_above_rise(above[1]),
        .hs_rail_below_fall(below[1]), .gate_drive_setpoint,
        .buck_switch_freq_sel, .buck_on_cycles, .buck_output_overvoltage,
        .buck_peak_current, .ext_warning, .status_clear, .gate_out,
        .strong_pulldown, .buck_hs_on, .buck_ls_on, .buck_target,
        .gate_drive_voltage, .buck_ocp_fault, .fault_status_reg,
        .fault_out_n
    );
    dsp_mcu i_dsp_mcu (
        .clk, .rst, .want_en, .want_freq, .clr_req, .slow, .want_setpt,
        .driver_enable_pin, .buck_switch_freq_sel, .status_clear,
        .gate_drive_setpoint
    );
    initial forever #4 clk = ~clk;
    function logic [7:0] rnd();
        lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        return lfsr;
    endfunction
    function logic [15:0] obs(logic [3:0] s);
        case (s)
            4'h0: obs = {10'h0, gate_out};
            4'h1: obs = {10'h0, strong_pulldown};
            4'h2: obs = {4'h0, buck_target, gate_drive_voltage};
            4'h3: obs = {8'h0, fault_status_reg};
            4'h4: obs = {14'h0, buck_ocp_fault, fault_out_n};
            4'h5: obs = per[15:0];
            4'h6: obs = 16'(rises - base);
            default: obs = {14'h0, buck_hs_on, buck_ls_on};
        endcase
    endfunction
    task chk(logic [15:0] seen, logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task want(logic [3:0] s, logic [15:0] v);
        exp_q.push_back({s, v});
        ->look;
    endtask
    task tk(int k);
        repeat (k) @(negedge clk);
    endtask
    task do_rst(logic f);
        want_freq <= f;
        rst <= 1;
        tk(10);
        rst <= 0;
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(look) begin
        while (exp_q.size() > 0) begin
            chk(obs(exp_q[0][19:16]), exp_q[0][15:0]);
            void'(exp_q.pop_front());
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test;
        end
    end
    always @(posedge buck_hs_on) begin
        per = cyc - last_rise;
        last_rise = cyc;
        rises++;
    end
    // marked periods 1..9, three clean, then marked again from 13
    always @(negedge clk)
        buck_peak_current <= ocp_on && buck_hs_on &&
            (rises - base < 10 || rises - base > 12);
    initial begin
        do_rst(0);
        pwm_in <= 6'h3f;
        want_en <= 1;
        tk(3);
        want(0, 0);
        above <= 2'b11;
        tk(3);
        repeat (8) begin
            r = rnd();
            pwm_in <= r[5:0];
            tk(1);
            want(0, r[5:0]);
        end
        r = rnd();
        gate_voltage_high <= r[5:0];
        want_en <= 0;
        tk(3);
        want(1, r[5:0]);
        want(0, 0);
        want_en <= 1;
        chip_enable <= 0;
        tk(3);
        want(1, r[5:0]);
        chip_enable <= 1;
        tk(3);
        want(1, 0);
        for (i = 0; i < 2; i++) begin
            above[i] <= 0;
            below[i] <= 1;
            per = 0;
            tk(3);
            want(0, 0);
            want(3, i ? 16'h3 : 16'h1);
            want(4, 0);
            tk(600);
            want(5, 250);
            above[i] <= 1;
            below[i] <= 0;
            tk(3);
            want(4, 1);
        end
        for (i = 0; i < 4; i++) begin
            want_setpt <= i[1:0];
            tk(3);
            want(2, {tgt[i], drv[i]});
        end
        ext_warning <= 1;
        tk(2);
        want(3, 16'h13);
        ext_warning <= 0;
        clr_req <= 1;
        tk(1);
        clr_req <= 0;
        tk(4);
        want(3, 0);
        want(4, 1);
        buck_output_overvoltage <= 1;
        tk(300);
        want(7, 0);
        want(3, 16'h04);
        buck_output_overvoltage <= 0;
        do_rst(1);
        r = rnd();
        buck_on_cycles <= 8'h10 + r[4:0];
        base = rises;
        ocp_on = 1;
        for (n = 0; n < 5000 && buck_ocp_fault !== 1'b1; n++)
            tk(1);
        want(6, 28);
        want(4, 16'h2);
        want(3, 16'h08);
        per = 0;
        tk(300);
        want(5, 125);
        ocp_on = 0;
        tk(700);
        want(4, 16'h1);
        want(3, 16'h08);
        slow <= 1;
        clr_req <= 1;
        tk(1);
        clr_req <= 0;
        tk(8);
        want(3, 0);
        tk(1);
        end_of_test;
    end
endmodule

bind dsp_protect dsp_chk i_dsp_chk (
    .clk, .rst, .chip_enable, .driver_enable_pin, .gate_voltage_high,
    .gate_drive_setpoint, .buck_output_overvoltage, .buck_peak_current,
    .ext_warning, .status_clear, .strong_pulldown, .buck_hs_on,
    .buck_ls_on, .buck_target, .gate_drive_voltage, .buck_ocp_fault,
    .fault_status_reg, .fault_out_n
);
